// ---- logic/hrr_homing.sv ----
// Homing reference-run sequencer for a position-controlled drive.
`timescale 1ns/10ps

module hrr_homing (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Run request and chosen reference-run type.
  input  wire logic        homeStart,
  input  wire logic [5:0]  homeType,
  // Reference sources, active high.
  input  wire logic        limNeg,
  input  wire logic        limPos,
  input  wire logic        refCam,
  input  wire logic        zeroPulse,
  // Command to the velocity loop.
  output logic             moveEn_q,
  output logic             dirPos_q,
  // Status to the position logic.
  output logic             homeBusy_q,
  output logic             homeDone_q,
  output logic             zeroMark_q,
  output logic             posKeep_q,
  output logic             typeFault_q
);

  // ----------------------------------------------------------------
  // Phase plan functions
  // ----------------------------------------------------------------

  // Plan for a base type 1..14: {start dir, reversal, arming event}.
  // The cam level at start picks between the two documented paths.
  function automatic logic [6:0] planFor(input logic [5:0] b,
                                         input logic       cam);
    logic [6:0] p;
    p = {1'b0, hrr_pkg::EV_NONE, hrr_pkg::EV_NONE};
    case (b)
      6'h01: p = {1'b0, hrr_pkg::EV_LRISE, hrr_pkg::EV_LFALL};
      6'h02: p = {1'b1, hrr_pkg::EV_LRISE, hrr_pkg::EV_LFALL};
      6'h03: p = cam ? {1'b0, hrr_pkg::EV_NONE,  hrr_pkg::EV_CFALL}
                     : {1'b1, hrr_pkg::EV_CRISE, hrr_pkg::EV_CFALL};
      6'h04: p = cam ? {1'b0, hrr_pkg::EV_CFALL, hrr_pkg::EV_CRISE}
                     : {1'b1, hrr_pkg::EV_NONE,  hrr_pkg::EV_CRISE};
      6'h05: p = cam ? {1'b1, hrr_pkg::EV_NONE,  hrr_pkg::EV_CFALL}
                     : {1'b0, hrr_pkg::EV_CRISE, hrr_pkg::EV_CFALL};
      6'h06: p = cam ? {1'b1, hrr_pkg::EV_CFALL, hrr_pkg::EV_CRISE}
                     : {1'b0, hrr_pkg::EV_NONE,  hrr_pkg::EV_CRISE};
      6'h07: p = cam ? {1'b0, hrr_pkg::EV_NONE,  hrr_pkg::EV_CFALL}
                     : {1'b1, hrr_pkg::EV_CACT,  hrr_pkg::EV_CFALL};
      6'h08: p = cam ? {1'b0, hrr_pkg::EV_CFALL, hrr_pkg::EV_CRISE}
                     : {1'b1, hrr_pkg::EV_NONE,  hrr_pkg::EV_CACT};
      6'h09: p = cam ? {1'b1, hrr_pkg::EV_CFALL, hrr_pkg::EV_CRISE}
                     : {1'b1, hrr_pkg::EV_CPASS, hrr_pkg::EV_CRISE};
      6'h0a: p = cam ? {1'b1, hrr_pkg::EV_NONE,  hrr_pkg::EV_CRISE}
                     : {1'b1, hrr_pkg::EV_NONE,  hrr_pkg::EV_CPASS};
      6'h0b: p = cam ? {1'b1, hrr_pkg::EV_NONE,  hrr_pkg::EV_CFALL}
                     : {1'b0, hrr_pkg::EV_CACT,  hrr_pkg::EV_CFALL};
      6'h0c: p = cam ? {1'b1, hrr_pkg::EV_CFALL, hrr_pkg::EV_CRISE}
                     : {1'b0, hrr_pkg::EV_NONE,  hrr_pkg::EV_CACT};
      6'h0d: p = cam ? {1'b0, hrr_pkg::EV_CFALL, hrr_pkg::EV_CRISE}
                     : {1'b0, hrr_pkg::EV_CPASS, hrr_pkg::EV_CRISE};
      6'h0e: p = cam ? {1'b0, hrr_pkg::EV_NONE,  hrr_pkg::EV_CFALL}
                     : {1'b0, hrr_pkg::EV_NONE,  hrr_pkg::EV_CPASS};
      default: p = {1'b0, hrr_pkg::EV_NONE, hrr_pkg::EV_NONE};
    endcase
    return p;
  endfunction

  // Plan after the travel-side limit reversed a cam run:
  // {reversal, arming event}. Types 7..10 and 11..14 share it.
  function automatic logic [5:0] limPlan(input logic [5:0] b);
    logic [5:0] p;
    p = {hrr_pkg::EV_NONE, hrr_pkg::EV_NONE};
    case (b)
      6'h07, 6'h0b: p = {hrr_pkg::EV_NONE,  hrr_pkg::EV_CPASS};
      6'h08, 6'h0c: p = {hrr_pkg::EV_CPASS, hrr_pkg::EV_CRISE};
      6'h09, 6'h0d: p = {hrr_pkg::EV_NONE,  hrr_pkg::EV_CACT};
      6'h0a, 6'h0e: p = {hrr_pkg::EV_CACT,  hrr_pkg::EV_CFALL};
      default:      p = {hrr_pkg::EV_NONE,  hrr_pkg::EV_NONE};
    endcase
    return p;
  endfunction

  // True when the event asked for has been seen this cycle.
  function automatic logic evMet(input logic [2:0] ev,
                                 input logic       cRise,
                                 input logic       cFall,
                                 input logic       cLvl,
                                 input logic       passed,
                                 input logic       lRise,
                                 input logic       lFall);
    logic m;
    m = 1'b0;
    case (ev)
      hrr_pkg::EV_NONE:  m = 1'b1;
      hrr_pkg::EV_CRISE: m = cRise;
      hrr_pkg::EV_CFALL: m = cFall;
      hrr_pkg::EV_CACT:  m = cLvl;
      hrr_pkg::EV_CPASS: m = passed;
      hrr_pkg::EV_LRISE: m = lRise;
      hrr_pkg::EV_LFALL: m = lFall;
      default:           m = 1'b0;
    endcase
    return m;
  endfunction

  // ----------------------------------------------------------------
  // Input edge detection
  // ----------------------------------------------------------------
  logic       camPrev_q;    // Cam level one cycle ago.
  logic       limNegPrev_q; // Negative limit one cycle ago.
  logic       limPosPrev_q; // Positive limit one cycle ago.
  logic       zpPrev_q;     // Zero pulse one cycle ago.

  // All sources are sampled on clk; edges are against last cycle.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      camPrev_q    <= 1'b0;
      limNegPrev_q <= 1'b0;
      limPosPrev_q <= 1'b0;
      zpPrev_q     <= 1'b0;
    end else begin
      camPrev_q    <= refCam;
      limNegPrev_q <= limNeg;
      limPosPrev_q <= limPos;
      zpPrev_q     <= zeroPulse;
    end
  end

  logic camRise;      // Cam became active.
  logic camFall;      // Cam became inactive.
  logic zpRise;       // Leading edge of the encoder zero pulse.
  logic limNegRise;   // Negative limit became active.
  logic limNegFall;   // Negative limit became inactive.
  logic limPosRise;   // Positive limit became active.
  logic limPosFall;   // Positive limit became inactive.

  assign camRise    = refCam & ~camPrev_q;
  assign camFall    = ~refCam & camPrev_q;
  assign zpRise     = zeroPulse & ~zpPrev_q;
  assign limNegRise = limNeg & ~limNegPrev_q;
  assign limNegFall = ~limNeg & limNegPrev_q;
  assign limPosRise = limPos & ~limPosPrev_q;
  assign limPosFall = ~limPos & limPosPrev_q;

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  hrr_pkg::hrr_state_t state_q;   // Current phase.
  logic [5:0]          base_q;    // Base type 1..14 of the run.
  logic [2:0]          revEv_q;   // Event that reverses the drive.
  logic [2:0]          armEv_q;   // Event that arms the zero search.
  logic                noZp_q;    // Zero on the edge, not the pulse.
  logic                homeNeg_q; // Home limit is the negative one.
  logic                limUsed_q; // Travel limit already reversed us.
  logic                seenRise_q; // Cam rose during this phase.

  // Home limit edges, chosen once per run.
  logic homeLimRise;
  logic homeLimFall;
  assign homeLimRise = homeNeg_q ? limNegRise : limPosRise;
  assign homeLimFall = homeNeg_q ? limNegFall : limPosFall;

  // Cam passed: a falling edge after a rise in the same phase.
  logic camPassed;
  assign camPassed = seenRise_q & camFall;

  // Limit ahead of travel became active; only cam runs 7..14 use it.
  logic travLimHit;
  logic limRunType;
  assign travLimHit = dirPos_q ? limPosRise : limNegRise;
  assign limRunType = (base_q >= hrr_pkg::TYPE_PLIM_LO) &&
                      (base_q <= hrr_pkg::TYPE_BASE_HI);

  logic revMet;       // Reversal event seen.
  logic armMet;       // Arming event seen.
  assign revMet = evMet(revEv_q, camRise, camFall, refCam, camPassed,
                        homeLimRise, homeLimFall);
  assign armMet = evMet(armEv_q, camRise, camFall, refCam, camPassed,
                        homeLimRise, homeLimFall);

  // Type decode of the request.
  logic       isBase;   // Types 1..14.
  logic       isNoZp;   // Types 17..30.
  logic       isZpOnly; // Types 33, 34.
  logic [5:0] reqBase;  // Base type used for the plan.
  logic [6:0] reqPlan;  // Plan picked at start.
  logic [5:0] lPlan;    // Plan after a limit reversal.
  assign isBase   = (homeType >= hrr_pkg::TYPE_NEG_LIM) &&
                    (homeType <= hrr_pkg::TYPE_BASE_HI);
  assign isNoZp   = (homeType >= hrr_pkg::TYPE_NOZP_LO) &&
                    (homeType <= hrr_pkg::TYPE_NOZP_HI);
  assign isZpOnly = (homeType == hrr_pkg::TYPE_ZP_NEG) ||
                    (homeType == hrr_pkg::TYPE_ZP_POS);
  assign reqBase  = isNoZp ? homeType - hrr_pkg::TYPE_NOZP_OFS
                           : homeType;
  assign reqPlan  = planFor(reqBase, refCam);
  assign lPlan    = limPlan(base_q);

  // ----------------------------------------------------------------
  // Phase sequencing
  // ----------------------------------------------------------------
  // One process owns the phase and its plan so that a reversal and
  // a plan swap can never disagree in the same cycle.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q    <= hrr_pkg::ST_IDLE;
      base_q     <= 6'h00;
      revEv_q    <= hrr_pkg::EV_NONE;
      armEv_q    <= hrr_pkg::EV_NONE;
      noZp_q     <= 1'b0;
      homeNeg_q  <= 1'b0;
      limUsed_q  <= 1'b0;
      seenRise_q <= 1'b0;
      dirPos_q   <= hrr_pkg::DIR_RST;
    end else begin
      case (state_q)
        // A start is only taken while not moving; repeat starts
        // after a finished or refused run are allowed.
        hrr_pkg::ST_IDLE, hrr_pkg::ST_DONE, hrr_pkg::ST_FAULT: begin
          if (homeStart) begin
            limUsed_q  <= 1'b0;
            seenRise_q <= 1'b0;
            noZp_q     <= isNoZp;
            base_q     <= reqBase;
            homeNeg_q  <= (reqBase == hrr_pkg::TYPE_NEG_LIM);
            if (isBase || isNoZp) begin
              dirPos_q <= reqPlan[6];
              revEv_q  <= reqPlan[5:3];
              armEv_q  <= reqPlan[2:0];
              state_q  <= hrr_pkg::ST_REV;
            end else if (isZpOnly) begin
              // Pulse-only runs just wait for the next pulse.
              dirPos_q <= (homeType == hrr_pkg::TYPE_ZP_POS);
              revEv_q  <= hrr_pkg::EV_NONE;
              armEv_q  <= hrr_pkg::EV_NONE;
              state_q  <= hrr_pkg::ST_ZERO;
            end else if (homeType == hrr_pkg::TYPE_ACTUAL) begin
              state_q  <= hrr_pkg::ST_DONE;
            end else begin
              state_q  <= hrr_pkg::ST_FAULT;
            end
          end
        end
        // Moving toward the first reversal point.
        hrr_pkg::ST_REV: begin
          if (limRunType && !limUsed_q && travLimHit) begin
            dirPos_q   <= ~dirPos_q;
            revEv_q    <= lPlan[5:3];
            armEv_q    <= lPlan[2:0];
            limUsed_q  <= 1'b1;
            seenRise_q <= 1'b0;
          end else if (revMet) begin
            if (revEv_q != hrr_pkg::EV_NONE) begin
              dirPos_q <= ~dirPos_q;
            end
            seenRise_q <= 1'b0;
            state_q    <= hrr_pkg::ST_ARM;
          end else if (camRise) begin
            seenRise_q <= 1'b1;
          end
        end
        // Moving until the edge that arms the zero search.
        hrr_pkg::ST_ARM: begin
          if (limRunType && !limUsed_q && travLimHit) begin
            dirPos_q   <= ~dirPos_q;
            revEv_q    <= lPlan[5:3];
            armEv_q    <= lPlan[2:0];
            limUsed_q  <= 1'b1;
            seenRise_q <= 1'b0;
            state_q    <= hrr_pkg::ST_REV;
          end else if (armMet) begin
            // Edge-only types latch on the edge itself.
            state_q <= noZp_q ? hrr_pkg::ST_DONE
                              : hrr_pkg::ST_ZERO;
          end else if (camRise) begin
            seenRise_q <= 1'b1;
          end
        end
        // A pulse coinciding with the arming edge is not taken;
        // the first pulse after it is.
        hrr_pkg::ST_ZERO: begin
          if (zpRise) begin
            state_q <= hrr_pkg::ST_DONE;
          end
        end
        default: state_q <= hrr_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic movingNow;   // Phase in which the drive must travel.
  logic latchNow;    // Zero point is latched this cycle.
  assign movingNow = (state_q == hrr_pkg::ST_REV) ||
                     (state_q == hrr_pkg::ST_ARM) ||
                     (state_q == hrr_pkg::ST_ZERO);
  assign latchNow  = (state_q != hrr_pkg::ST_DONE) &&
                     (state_q != hrr_pkg::ST_IDLE) &&
                     (state_q != hrr_pkg::ST_FAULT) &&
                     ((state_q == hrr_pkg::ST_ZERO && zpRise) ||
                      (state_q == hrr_pkg::ST_ARM && noZp_q &&
                       armMet && !(limRunType && !limUsed_q &&
                                   travLimHit)));

  // Status is registered one cycle after the phase so that every
  // output comes straight from a flip-flop.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      moveEn_q    <= 1'b0;
      homeBusy_q  <= 1'b0;
      homeDone_q  <= 1'b0;
      zeroMark_q  <= 1'b0;
      posKeep_q   <= 1'b0;
      typeFault_q <= 1'b0;
    end else begin
      moveEn_q   <= movingNow & ~latchNow;
      homeBusy_q <= movingNow & ~latchNow;
      zeroMark_q <= latchNow ||
                    (homeStart && !movingNow &&
                     homeType == hrr_pkg::TYPE_ACTUAL);
      if (homeStart && !movingNow) begin
        homeDone_q  <= (homeType == hrr_pkg::TYPE_ACTUAL);
        posKeep_q   <= (homeType == hrr_pkg::TYPE_ACTUAL);
        typeFault_q <= !(isBase || isNoZp || isZpOnly ||
                         homeType == hrr_pkg::TYPE_ACTUAL);
      end else if (latchNow) begin
        homeDone_q <= 1'b1;
      end
    end
  end

endmodule // hrr_homing

// ---- inc/hrr_pkg.sv ----
// Constants and types shared by the homing reference-run sequencer.
package hrr_pkg;

  // ----------------------------------------------------------------
  // Reference-run type numbers
  // ----------------------------------------------------------------
  localparam int          TYPE_W        = 6;
  localparam logic [5:0]  TYPE_NEG_LIM  = 6'h01; // Negative limit run.
  localparam logic [5:0]  TYPE_POS_LIM  = 6'h02; // Positive limit run.
  localparam logic [5:0]  TYPE_CAM_LO   = 6'h03; // First cam type.
  localparam logic [5:0]  TYPE_PLIM_LO  = 6'h07; // First pos-limit cam type.
  localparam logic [5:0]  TYPE_NLIM_LO  = 6'h0b; // First neg-limit cam type.
  localparam logic [5:0]  TYPE_BASE_HI  = 6'h0e; // Last base type.
  localparam logic [5:0]  TYPE_NOZP_LO  = 6'h11; // First edge-only type.
  localparam logic [5:0]  TYPE_NOZP_HI  = 6'h1e; // Last edge-only type.
  localparam logic [5:0]  TYPE_NOZP_OFS = 6'h10; // Edge-only to base.
  localparam logic [5:0]  TYPE_ZP_NEG   = 6'h21; // Pulse only, negative.
  localparam logic [5:0]  TYPE_ZP_POS   = 6'h22; // Pulse only, positive.
  localparam logic [5:0]  TYPE_ACTUAL   = 6'h23; // Actual position.

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic        DIR_RST       = 1'h0;  // Negative at rest.

  // ----------------------------------------------------------------
  // Event conditions that end a phase
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    EV_NONE  = 3'h0,  // Met at once.
    EV_CRISE = 3'h1,  // Cam becomes active.
    EV_CFALL = 3'h2,  // Cam becomes inactive.
    EV_CACT  = 3'h3,  // Cam is active.
    EV_CPASS = 3'h4,  // Cam passed: rise then fall.
    EV_LRISE = 3'h5,  // Home limit becomes active.
    EV_LFALL = 3'h6   // Home limit becomes inactive.
  } hrr_ev_t;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,  // Waiting for a start.
    ST_REV   = 3'h1,  // Moving, waiting for the reversal event.
    ST_ARM   = 3'h2,  // Moving, waiting for the arming event.
    ST_ZERO  = 3'h3,  // Armed, waiting for the encoder zero pulse.
    ST_DONE  = 3'h4,  // Zero point latched.
    ST_FAULT = 3'h5   // Type has no defined behaviour.
  } hrr_state_t;

endpackage

// ---- dv/hrr_homing_sva.sv ----
// Assertion checker bound to the homing sequencer ports.
`timescale 1ns/10ps
module hrr_homing_sva (
  // Clock and reset.
  input wire logic       clk,
  input wire logic       sys_rst,
  // Run request and reference sources.
  input wire logic       homeStart,
  input wire logic [5:0] homeType,
  input wire logic       refCam,
  input wire logic       zeroPulse,
  // Sequencer outputs.
  input wire logic       moveEn_q,
  input wire logic       dirPos_q,
  input wire logic       homeBusy_q,
  input wire logic       homeDone_q,
  input wire logic       zeroMark_q,
  input wire logic       posKeep_q,
  input wire logic       typeFault_q
);
  // ------------------------------------------------------------
  // Start tracking
  // ------------------------------------------------------------
  logic       take;   // A start is taken at this edge.
  logic       took_q; // A start was taken one edge ago.
  logic [5:0] run_q;  // Type of the latest taken start.
  // Busy shows two edges late, so the edge after a start is blocked here.
  assign take = homeStart && !homeBusy_q && !took_q;
  always_ff @(posedge clk) begin
    took_q <= !sys_rst && take;
    run_q  <= sys_rst ? 6'h00 : (take ? homeType : run_q);
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_take(logic [5:0] t); take && homeType == t; endsequence
  sequence s_launch; dirPos_q ##1 moveEn_q; endsequence
  sequence s_halt; homeDone_q && !moveEn_q ##1 !zeroMark_q; endsequence
  // The first direction is set one edge after the start.
  property p_type2; s_take(6'h02) |=> s_launch; endproperty
  a_type2: assert property (p_type2) else $error("type 2 launch");
  property p_cam34;
    take && homeType inside {6'h03, 6'h04} |=> dirPos_q == !$past(refCam);
  endproperty
  a_cam34: assert property (p_cam34) else $error("type 3/4 dir");
  property p_cam710;
    take && homeType inside {[6'h07:6'h0a]} |=>
      dirPos_q == ($past(homeType) >= 6'h09 || !$past(refCam));
  endproperty
  a_cam710: assert property (p_cam710) else $error("7-10 dir");
  property p_cam1114;
    take && homeType inside {[6'h0b:6'h0e]} |=>
      dirPos_q == ($past(homeType) <= 6'h0c && $past(refCam));
  endproperty
  a_cam1114: assert property (p_cam1114) else $error("dir bad");
  property p_actual;
    s_take(6'h23) |=> posKeep_q && homeDone_q && zeroMark_q && !moveEn_q;
  endproperty
  a_actual: assert property (p_actual) else $error("type 35 result");
  property p_undef;
    take && (homeType inside {6'h00, 6'h0f, 6'h10, 6'h1f, 6'h20}
      || homeType > 6'h23) |=> typeFault_q ##1 !moveEn_q;
  endproperty
  a_undef: assert property (p_undef) else $error("undefined type");
  // A pulse-referenced zero needs a fresh rising zero-pulse edge.
  property p_latch;
    zeroMark_q && (run_q <= 6'h0e || run_q inside {6'h21, 6'h22}) |->
      $past(zeroPulse) && !$past(zeroPulse, 2);
  endproperty
  a_latch: assert property (p_latch) else $error("latch w/o pulse");
  property p_stop; $rose(zeroMark_q) |-> s_halt; endproperty
  a_stop: assert property (p_stop) else $error("latch did not stop");
endmodule // hrr_homing_sva
bind hrr_homing hrr_homing_sva u_hrr_homing_sva (.clk(clk),
  .sys_rst(sys_rst), .homeStart(homeStart), .homeType(homeType),
  .refCam(refCam), .zeroPulse(zeroPulse), .moveEn_q(moveEn_q),
  .dirPos_q(dirPos_q), .homeBusy_q(homeBusy_q), .homeDone_q(homeDone_q),
  .zeroMark_q(zeroMark_q), .posKeep_q(posKeep_q),
  .typeFault_q(typeFault_q));

// ---- dv/hrr_axis_model.sv ----
// Axis model: limit switches, reference cam and encoder zero pulse.
`timescale 1ns/10ps
module hrr_axis_model #(
  parameter int CAM_LO   = 100, // First position with the cam active.
  parameter int CAM_HI   = 120, // Last position with the cam active.
  parameter int LIM_POS  = 200, // Positive limit active from here on.
  parameter int ZP_PITCH = 16   // Positions between zero pulses.
) (
  // Clock and position preset.
  input  wire logic        clk,
  input  wire logic        setPos,
  input  wire logic [31:0] newPos,
  // Motion command from the sequencer.
  input  wire logic        moveEn_q,
  input  wire logic        dirPos_q,
  // Reference sources, active high.
  output logic             limNeg,
  output logic             limPos,
  output logic             refCam,
  output logic             zeroPulse,
  // Position at which the latest zero pulse was seen.
  output logic [31:0]      lastZp
);
  // ------------------------------------------------------------
  // Axis position and reference levels
  // ------------------------------------------------------------
  int pos_q; // Axis position.
  // One step per moving cycle; a real drive would coast, not modelled.
  always_ff @(posedge clk) begin
    if (setPos) pos_q <= $signed(newPos);
    else if (moveEn_q) pos_q <= dirPos_q ? pos_q + 1 : pos_q - 1;
    if (zeroPulse) lastZp <= pos_q;
  end
  // Levels follow position; the zero pulse is one position wide.
  assign limNeg    = pos_q <= 0;
  assign limPos    = pos_q >= LIM_POS;
  assign refCam    = pos_q >= CAM_LO && pos_q <= CAM_HI;
  assign zeroPulse = pos_q % ZP_PITCH == 0;
endmodule // hrr_axis_model

// ---- dv/testbench.sv ----
// Self-checking bench for the homing sequencer with an axis model.
`timescale 1ns/10ps
module testbench;
  logic        clk = 1'b0, sys_rst = 1'b1, homeStart = 1'b0, setPos = 1'b1;
  logic [5:0]  homeType = 6'h00;
  logic        limNeg, limPos, refCam, zeroPulse;
  logic        moveEn_q, dirPos_q, homeBusy_q, homeDone_q;
  logic        zeroMark_q, posKeep_q, typeFault_q;
  logic [31:0] lastZp;
  int          newPos = 50, miscompares = 0, total_checks = 0;
  int          seed = 32'h82ee5b9f;
  int          expZero[$];  // Expected zero points; -1 skips the position.
  // Type, start position, first direction, zero point; -2 marks a refusal.
  int runs[45][4] = '{'{2,150,1,192}, '{3,50,1,96}, '{4,50,1,112},
    '{3,110,0,96}, '{4,110,0,112}, '{5,110,1,128}, '{6,110,1,112},
    '{5,150,0,128}, '{6,150,0,112}, '{7,50,1,96}, '{8,50,1,112},
    '{9,50,1,112}, '{10,50,1,128}, '{7,110,0,96}, '{8,110,0,112},
    '{9,110,1,112}, '{7,150,1,96}, '{8,150,1,112}, '{9,150,1,112},
    '{10,150,1,128}, '{11,150,0,128}, '{12,150,0,112}, '{13,150,0,112},
    '{14,150,0,96}, '{13,110,0,112}, '{14,110,0,96}, '{11,110,1,128},
    '{12,110,1,112}, '{11,50,0,128}, '{12,50,0,112}, '{13,50,0,112},
    '{14,50,0,96}, '{33,50,0,48}, '{34,50,1,64}, '{1,50,0,16},
    '{18,150,1,-1}, '{20,50,1,-1}, '{35,50,0,-1}, '{0,50,0,-2},
    '{15,50,0,-2}, '{16,50,0,-2}, '{31,50,0,-2}, '{32,50,0,-2},
    '{36,50,0,-2}, '{63,50,0,-2}};
  // ------------------------------------------------------------
  // Sequencer and axis model
  // ------------------------------------------------------------
  hrr_homing u_hrr_homing (.clk(clk), .sys_rst(sys_rst),
    .homeStart(homeStart), .homeType(homeType), .limNeg(limNeg),
    .limPos(limPos), .refCam(refCam), .zeroPulse(zeroPulse),
    .moveEn_q(moveEn_q), .dirPos_q(dirPos_q), .homeBusy_q(homeBusy_q),
    .homeDone_q(homeDone_q), .zeroMark_q(zeroMark_q),
    .posKeep_q(posKeep_q), .typeFault_q(typeFault_q));
  hrr_axis_model u_hrr_axis_model (.clk(clk), .setPos(setPos),
    .newPos(newPos), .moveEn_q(moveEn_q), .dirPos_q(dirPos_q),
    .limNeg(limNeg), .limPos(limPos), .refCam(refCam),
    .zeroPulse(zeroPulse), .lastZp(lastZp));
  always #5 clk = ~clk;
  // ------------------------------------------------------------
  // Checks and verdict
  // ------------------------------------------------------------
  // Counts every compare and reports a difference at once.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    if (miscompares == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Each latch takes the oldest expected zero point off the queue.
  always @(negedge clk) begin
    if (zeroMark_q === 1'b1) begin
      check(homeDone_q, 1'b1);
      check(moveEn_q, 1'b0);
      check(expZero.size() > 0, 1'b1);
      if (expZero.size() > 0 && expZero[0] >= 0)
        check(lastZp, expZero[0]);
      if (expZero.size() > 0) void'(expZero.pop_front());
    end
  end
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  // Places the axis, starts one run, pokes an ignored start in moving runs below type 33, then waits.
  task automatic run(input int t, input int s, input int d, input int z);
    int n;
    setPos = 1'b1;
    newPos = s;
    @(negedge clk);
    setPos = 1'b0;
    repeat (1 + ($random(seed) & 3)) @(negedge clk);
    if (z != -2) expZero.push_back(z);
    homeStart = 1'b1;
    homeType = 6'(t);
    @(negedge clk);
    homeStart = 1'b0;
    @(negedge clk);
    check(typeFault_q, z == -2);
    check(posKeep_q, t == 35);
    // Moving runs show motion two edges after the start; others never.
    check(moveEn_q, z != -2 && t != 35);
    check(homeBusy_q, z != -2 && t != 35);
    if (z == -2) begin
      check(homeDone_q, 1'b0);
      return;
    end
    if (t != 35) check(dirPos_q, d[0]);
    // A start while moving must be ignored; a random type stresses it.
    if (t < 33) begin
      repeat (4) @(negedge clk);
      homeStart = 1'b1;
      homeType = 6'($random(seed));
      @(negedge clk);
      homeStart = 1'b0;
    end
    for (n = 0; n < 3000 && homeDone_q !== 1'b1; n++) @(negedge clk);
    if (n == 3000) begin
      miscompares++;
      conclude();
    end
    @(negedge clk);
  endtask
  initial begin
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    check({moveEn_q, homeBusy_q, homeDone_q, zeroMark_q}, 4'h0);
    foreach (runs[i]) run(runs[i][0], runs[i][1], runs[i][2], runs[i][3]);
    conclude();
  end
endmodule // testbench
